// ==== hdl/fpw_top.sv ====
// Function
// - 77h, 24 dummy bits, then wrap byte captured
// - only wrap bits six to four matter
// - disable bit 0 wraps 8/16/32/64 bytes
// - quad reads use stored wrap setting
// - wrap disabled after any reset
// - four-wire mode keeps length, parameter command updates
// - 02h plus address plus data needs latch set
// - program one to 256 bytes of page
// - low eight address bits wrap within page
// - execute only if select rises on boundary
// - busy during self-timed program, status stays readable
// - program completion clears write enable latch
// - protected or locked page not programmed
// - 32h quad program needs quad enable bit
// - 20h erases addressed 4 KB sector
// - sector erase busy, then clears busy, latch
// - protected or locked sector not erased
// - 52h erases addressed 32 KB block
// - block erase busy, clears latch, honours protection
`timescale 1ns/10ps
`default_nettype none
module fpw_top
  import fpw_pkg::*;
#(
  parameter int PP_CYCLES = FPW_PP_CYCLES,
  parameter int SE_CYCLES = FPW_SE_CYCLES,
  parameter int BE32_CYCLES = FPW_BE32_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [3:0] data_line_i,
  input wire logic four_wire_command_mode_i,
  input wire logic quad_enable_bit_i,
  input wire logic latch_set_i,
  input wire fpw_prot_s prot_i,
  input wire logic locked_i,
  input wire logic param_wrap_set_i,
  input wire logic [1:0] param_wrap_len_i,
  input wire logic [23:0] rd_addr_i,
  output logic [23:0] rd_next_addr_o,
  output logic busy_o,
  output logic write_enable_latch_o,
  output logic wrap_disable_bit_o,
  output logic [1:0] wrap_length_field_o,
  output logic [23:0] target_addr_o,
  output fpw_arr_wr_s arr_wr_o,
  output logic erase_o,
  output logic erase_blk32_o
);

  // ****************************************
  // reset release and pin synchronisers
  // ****************************************
  logic rst_n_q1_r;
  logic rst_n;
  logic [5:0] pin_s1_r;
  logic [5:0] pin_s2_r;
  logic sclk_d_r;
  logic cs_n_d_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_n_q1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_n_q1_r <= 1'b1;
      rst_n <= rst_n_q1_r;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 6'h3f;
      pin_s2_r <= 6'h3f;
      sclk_d_r <= 1'b1;
      cs_n_d_r <= 1'b1;
    end else begin
      pin_s1_r <= {cs_n_i, sclk_i, data_line_i};
      pin_s2_r <= pin_s1_r;
      sclk_d_r <= pin_s2_r[4];
      cs_n_d_r <= pin_s2_r[5];
    end
  end

  // ****************************************
  // bit and byte assembly
  // ****************************************
  logic cs_low;
  logic sclk_rise;
  logic cs_rise;
  logic [3:0] din;
  logic quad_r;
  logic [2:0] bitcnt_r;
  logic [7:0] shift_r;
  logic [3:0] cnt_sum;
  logic [7:0] shift_nxt;
  logic byte_done;

  assign cs_low = ~pin_s2_r[5];
  assign cs_rise = pin_s2_r[5] & ~cs_n_d_r;
  assign sclk_rise = cs_low & pin_s2_r[4] & ~sclk_d_r;
  assign din = pin_s2_r[3:0];
  assign cnt_sum = {1'b0, bitcnt_r} +
                   (quad_r ? FPW_STEP_QUAD : FPW_STEP_SERIAL);
  // upper nibble first, data_line_3 carries the highest bit
  assign shift_nxt = quad_r ? {shift_r[3:0], din} :
                     {shift_r[6:0], din[0]};
  assign byte_done = sclk_rise & cnt_sum[3];

  // ****************************************
  // command parser
  // ****************************************
  fpw_state_e state_r;
  fpw_op_e op_r;
  fpw_exec_e ex_r;
  logic busy_r;
  logic latch_r;
  logic [1:0] idx_r;
  logic [23:0] addr_r;
  logic [7:0] col_r;
  logic got_byte_r;
  logic [255:0] written_r;
  fpw_wrap_s wrap_r;
  logic four_wire;
  logic dec_prog;
  logic dec_quad;
  logic dec_sect;
  logic dec_blk;
  logic dec_wrap;
  logic data_we;
  logic prot_hit;
  logic frame_ok;
  logic start;

  assign four_wire = four_wire_command_mode_i;
  assign dec_prog = (shift_nxt == FPW_OPC_PAGE_PROG) & latch_r;
  assign dec_quad = (shift_nxt == FPW_OPC_QUAD_PROG) & latch_r &
                    quad_enable_bit_i & ~four_wire;
  assign dec_sect = (shift_nxt == FPW_OPC_SECT_ERASE) & latch_r;
  assign dec_blk = (shift_nxt == FPW_OPC_BLK32_ERASE) & latch_r;
  // wrap setup exists only in the single-line command mode
  assign dec_wrap = (shift_nxt == FPW_OPC_WRAP_SET) & ~four_wire;
  assign data_we = byte_done & (state_r == FPW_ST_DATA);

  // only a rise on a byte boundary of the complete frame counts
  assign frame_ok = (bitcnt_r == 3'h0) &
    (((state_r == FPW_ST_DATA) & got_byte_r) |
     (state_r == FPW_ST_END));
  assign start = cs_rise & frame_ok & ~busy_r &
                 ~prot_hit & ~locked_i;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= FPW_ST_OPC;
      op_r <= FPW_OP_PROG;
      quad_r <= 1'b0;
      bitcnt_r <= 3'h0;
      shift_r <= 8'h00;
      idx_r <= 2'h0;
      addr_r <= 24'h000000;
      col_r <= 8'h00;
      got_byte_r <= 1'b0;
    end else if (!cs_low) begin
      state_r <= FPW_ST_OPC;
      quad_r <= four_wire;
      bitcnt_r <= 3'h0;
      idx_r <= 2'h0;
      got_byte_r <= 1'b0;
    end else if (sclk_rise) begin
      shift_r <= shift_nxt;
      bitcnt_r <= cnt_sum[2:0];
      if (byte_done) begin
        unique case (state_r)
          FPW_ST_OPC: begin
            if (busy_r) begin
              state_r <= FPW_ST_IGNORE;
            end else if (dec_wrap) begin
              state_r <= FPW_ST_DUMMY;
            end else if (dec_prog | dec_quad) begin
              state_r <= FPW_ST_ADDR;
              op_r <= FPW_OP_PROG;
              quad_r <= quad_r | dec_quad;
            end else if (dec_sect | dec_blk) begin
              state_r <= FPW_ST_ADDR;
              op_r <= dec_sect ? FPW_OP_SECT : FPW_OP_BLK32;
            end else begin
              state_r <= FPW_ST_IGNORE;
            end
          end
          FPW_ST_ADDR: begin
            addr_r <= {addr_r[15:0], shift_nxt};
            col_r <= shift_nxt;
            idx_r <= idx_r + 2'h1;
            if (idx_r == FPW_ADDR_LAST) begin
              state_r <= (op_r == FPW_OP_PROG) ? FPW_ST_DATA : FPW_ST_END;
            end
          end
          FPW_ST_DUMMY: begin
            idx_r <= idx_r + 2'h1;
            if (idx_r == FPW_DUMMY_LAST) begin
              state_r <= FPW_ST_WRAP;
            end
          end
          FPW_ST_DATA: begin
            col_r <= col_r + 8'h01;
            got_byte_r <= 1'b1;
          end
          FPW_ST_WRAP, FPW_ST_END, FPW_ST_IGNORE: begin
            state_r <= FPW_ST_IGNORE;
          end
          default: begin
            state_r <= FPW_ST_IGNORE;
          end
        endcase
      end
    end
  end

  // ****************************************
  // wrap setting
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wrap_r.wrap_disable_bit <= FPW_WRAP_DIS_RST;
      wrap_r.wrap_length_field <= FPW_WRAP_LEN_RST;
    end else if (byte_done && state_r == FPW_ST_WRAP && !busy_r) begin
      // bit 7 and the low nibble are dropped here
      wrap_r.wrap_disable_bit <= shift_nxt[FPW_WRAP_DIS_POS];
      wrap_r.wrap_length_field <=
        shift_nxt[FPW_WRAP_LEN_LSB +: 2];
    end else if (param_wrap_set_i) begin
      wrap_r.wrap_length_field <= param_wrap_len_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_next_addr_o <= 24'h000000;
    end else begin
      rd_next_addr_o <= fpw_wrap_next(rd_addr_i, wrap_r);
    end
  end

  // ****************************************
  // page buffer and protection lookup
  // ****************************************
  logic [7:0] flush_idx_r;
  logic [7:0] pend_col_r;
  logic pend_r;
  logic flush_last_r;
  logic [7:0] buf_rdata;

  fpw_page_buf u_buf (
    .clk_i(clk_i),
    .we_i(data_we),
    .waddr_i(col_r),
    .wdata_i(shift_nxt),
    .raddr_i(flush_idx_r),
    .rdata_o(buf_rdata)
  );

  fpw_protect u_prot (
    .prot_i(prot_i),
    .byte_address_i(addr_r),
    .protected_o(prot_hit)
  );

  // a fresh program frame forgets the bytes of the previous one
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      written_r <= '0;
    end else if (byte_done && state_r == FPW_ST_OPC && !busy_r) begin
      written_r <= '0;
    end else if (data_we) begin
      written_r[col_r] <= 1'b1;
    end
  end

  // ****************************************
  // self-timed execution
  // ****************************************
  logic [23:0] timer_r;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ex_r <= FPW_EX_IDLE;
      busy_r <= 1'b0;
      timer_r <= 24'h000000;
      flush_idx_r <= 8'h00;
      pend_r <= 1'b0;
      pend_col_r <= 8'h00;
      flush_last_r <= 1'b0;
    end else begin
      pend_r <= 1'b0;
      unique case (ex_r)
        FPW_EX_IDLE: begin
          if (start) begin
            busy_r <= 1'b1;
            flush_idx_r <= 8'h00;
            flush_last_r <= 1'b0;
            unique case (op_r)
              FPW_OP_PROG: timer_r <= 24'(PP_CYCLES - 1);
              FPW_OP_SECT: timer_r <= 24'(SE_CYCLES - 1);
              default: timer_r <= 24'(BE32_CYCLES - 1);
            endcase
            ex_r <= (op_r == FPW_OP_PROG) ? FPW_EX_FLUSH : FPW_EX_WAIT;
          end
        end
        FPW_EX_FLUSH: begin
          // untouched bytes of the page get no write
          pend_r <= written_r[flush_idx_r];
          pend_col_r <= flush_idx_r;
          flush_idx_r <= flush_idx_r + 8'h01;
          if (flush_idx_r == FPW_COL_LAST) begin
            ex_r <= FPW_EX_WAIT;
          end
          if (timer_r != 24'h000000) begin
            timer_r <= timer_r - 24'h000001;
          end
        end
        FPW_EX_WAIT: begin
          if (timer_r == 24'h000000) begin
            busy_r <= 1'b0;
            ex_r <= FPW_EX_IDLE;
          end else begin
            timer_r <= timer_r - 24'h000001;
          end
        end
        default: begin
          ex_r <= FPW_EX_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  logic done;
  assign done = (ex_r == FPW_EX_WAIT) & (timer_r == 24'h000000);

  // a set request in the completion cycle wins over the clear
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      latch_r <= 1'b0;
    end else if (latch_set_i) begin
      latch_r <= 1'b1;
    end else if (done) begin
      latch_r <= 1'b0;
    end
  end

  // ****************************************
  // array side outputs
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      arr_wr_o <= '0;
      erase_o <= 1'b0;
      erase_blk32_o <= 1'b0;
    end else begin
      arr_wr_o.we <= pend_r;
      arr_wr_o.byte_address <= {addr_r[23:8], pend_col_r};
      arr_wr_o.data <= buf_rdata;
      erase_o <= start & (op_r != FPW_OP_PROG);
      if (start) begin
        erase_blk32_o <= (op_r == FPW_OP_BLK32);
      end
    end
  end

  assign busy_o = busy_r;
  assign write_enable_latch_o = latch_r;
  assign wrap_disable_bit_o = wrap_r.wrap_disable_bit;
  assign wrap_length_field_o = wrap_r.wrap_length_field;
  assign target_addr_o = addr_r;

endmodule : fpw_top
`default_nettype wire

// ==== hdl/fpw_pkg.sv ====
package fpw_pkg;

  // ****************************************
  // command codes and frame layout
  // ****************************************
  localparam logic [7:0] FPW_OPC_WRAP_SET = 8'h77;
  localparam logic [7:0] FPW_OPC_PAGE_PROG = 8'h02;
  localparam logic [7:0] FPW_OPC_QUAD_PROG = 8'h32;
  localparam logic [7:0] FPW_OPC_SECT_ERASE = 8'h20;
  localparam logic [7:0] FPW_OPC_BLK32_ERASE = 8'h52;
  localparam logic [1:0] FPW_ADDR_LAST = 2'h2;
  localparam logic [1:0] FPW_DUMMY_LAST = 2'h2;
  localparam int FPW_WRAP_DIS_POS = 4;
  localparam int FPW_WRAP_LEN_LSB = 5;
  localparam int FPW_PAGE_BYTES = 256;
  localparam logic [7:0] FPW_COL_LAST = 8'hff;
  localparam logic [3:0] FPW_STEP_SERIAL = 4'h1;
  localparam logic [3:0] FPW_STEP_QUAD = 4'h4;

  // ****************************************
  // reset values and protection geometry
  // ****************************************
  localparam logic FPW_WRAP_DIS_RST = 1'b1;
  localparam logic [1:0] FPW_WRAP_LEN_RST = 2'h0;
  localparam logic [10:0] FPW_SECTORS_ALL = 11'h400;
  localparam logic [10:0] FPW_SECTORS_PER_BLK = 11'h010;
  localparam logic [10:0] FPW_SECTORS_SMALL_MAX = 11'h008;

  // ****************************************
  // self-timed durations
  // ****************************************
  localparam int FPW_CLK_MHZ = 20;
  localparam int FPW_T_PP_US = 800;
  localparam int FPW_T_SE_US = 45000;
  localparam int FPW_T_BE32_US = 120000;
  localparam int FPW_PP_CYCLES = FPW_T_PP_US * FPW_CLK_MHZ;
  localparam int FPW_SE_CYCLES = FPW_T_SE_US * FPW_CLK_MHZ;
  localparam int FPW_BE32_CYCLES = FPW_T_BE32_US * FPW_CLK_MHZ;

  typedef enum logic [2:0] {
    FPW_ST_OPC = 3'b000,
    FPW_ST_ADDR = 3'b001,
    FPW_ST_DUMMY = 3'b010,
    FPW_ST_WRAP = 3'b011,
    FPW_ST_DATA = 3'b100,
    FPW_ST_END = 3'b101,
    FPW_ST_IGNORE = 3'b110
  } fpw_state_e;

  typedef enum logic [1:0] {
    FPW_OP_PROG = 2'b00,
    FPW_OP_SECT = 2'b01,
    FPW_OP_BLK32 = 2'b10
  } fpw_op_e;

  typedef enum logic [1:0] {
    FPW_EX_IDLE = 2'b00,
    FPW_EX_FLUSH = 2'b01,
    FPW_EX_WAIT = 2'b10
  } fpw_exec_e;

  typedef struct packed {
    logic protect_complement;
    logic small_unit_protect_select;
    logic top_bottom_select;
    logic block_protect_2;
    logic block_protect_1;
    logic block_protect_0;
  } fpw_prot_s;

  typedef struct packed {
    logic wrap_disable_bit;
    logic [1:0] wrap_length_field;
  } fpw_wrap_s;

  typedef struct packed {
    logic we;
    logic [23:0] byte_address;
    logic [7:0] data;
  } fpw_arr_wr_s;

  // next read address, held inside the wrap section when wrap is on
  function automatic logic [23:0] fpw_wrap_next(input logic [23:0] a,
                                                input fpw_wrap_s w);
    logic [7:0] mask;
    logic [23:0] inc;
    mask = 8'h07;
    inc = a + 24'h000001;
    case (w.wrap_length_field)
      2'h0: mask = 8'h07;
      2'h1: mask = 8'h0f;
      2'h2: mask = 8'h1f;
      default: mask = 8'h3f;
    endcase
    if (w.wrap_disable_bit) begin
      fpw_wrap_next = inc;
    end else begin
      fpw_wrap_next = {a[23:8], (a[7:0] & ~mask) | (inc[7:0] & mask)};
    end
  endfunction : fpw_wrap_next

endpackage : fpw_pkg

// ==== hdl/fpw_page_buf.sv ====
`timescale 1ns/10ps
`default_nettype none
module fpw_page_buf
  import fpw_pkg::*;
(
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [7:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] raddr_i,
  output logic [7:0] rdata_o
);

  logic [7:0] mem_r [FPW_PAGE_BYTES];

  // no reset: contents only matter where the written mask says so
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_r[raddr_i];
  end

endmodule : fpw_page_buf
`default_nettype wire

// ==== hdl/fpw_protect.sv ====
`timescale 1ns/10ps
`default_nettype none
module fpw_protect
  import fpw_pkg::*;
(
  input wire fpw_prot_s prot_i,
  input wire logic [23:0] byte_address_i,
  output logic protected_o
);

  // protected span counted in 4 KB sectors from the chosen end
  logic [2:0] bp;
  logic [10:0] span;
  logic [10:0] blk_span;
  logic [10:0] small_span;
  logic [10:0] sector;
  logic hit;

  assign bp = {prot_i.block_protect_2, prot_i.block_protect_1,
               prot_i.block_protect_0};
  assign sector = {1'b0, byte_address_i[21:12]};
  assign blk_span = FPW_SECTORS_PER_BLK << (bp - 3'h1);
  assign small_span = (bp > 3'h4) ? FPW_SECTORS_SMALL_MAX :
                    (11'h001 << (bp - 3'h1));
  assign span = (bp == 3'h0) ? 11'h000 :
                (bp == 3'h7) ? FPW_SECTORS_ALL :
                prot_i.small_unit_protect_select ? small_span : blk_span;
  assign hit = prot_i.top_bottom_select ? (sector < span) :
               (sector >= (FPW_SECTORS_ALL - span));
  assign protected_o = hit ^ prot_i.protect_complement;

endmodule : fpw_protect
`default_nettype wire

// ==== bench/fpw_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module fpw_checker
  import fpw_pkg::*;
#(
  parameter int PP_CYCLES = 300,
  parameter int SE_CYCLES = 400,
  parameter int BE32_CYCLES = 500
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic latch_set_i,
  input wire logic [23:0] rd_addr_i,
  input wire logic [23:0] rd_next_addr_o,
  input wire logic busy_o,
  input wire logic write_enable_latch_o,
  input wire logic wrap_disable_bit_o,
  input wire logic [1:0] wrap_length_field_o,
  input wire logic [23:0] target_addr_o,
  input wire fpw_arr_wr_s arr_wr_o,
  input wire logic erase_o,
  input wire logic erase_blk32_o
);
  // ****************************************
  // helper logic
  // ****************************************
  // design leaves reset two edges late; one more edge keeps $past clean
  logic [2:0] ok_r;
  int busy_cnt_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ok_r <= 3'h0;
      busy_cnt_r <= 0;
    end else begin
      ok_r <= {ok_r[1:0], 1'b1};
      busy_cnt_r <= busy_o ? busy_cnt_r + 1 : 0;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!ok_r[2]);
  // ****************************************
  // assertions
  // ****************************************
  AST_BUSY_WEL: assert property (
    $rose(busy_o) |-> $past(write_enable_latch_o))
    else $error("busy rose without latch");
  AST_WEL_CLR: assert property (
    $fell(busy_o) |-> !write_enable_latch_o || $past(latch_set_i))
    else $error("latch kept after completion");
  AST_BUSY_LEN: assert property (
    $fell(busy_o) |-> busy_cnt_r inside {[PP_CYCLES-1:PP_CYCLES+1],
      [SE_CYCLES-1:SE_CYCLES+1], [BE32_CYCLES-1:BE32_CYCLES+1]})
    else $error("busy length wrong");
  AST_ERASE_START: assert property (
    erase_o |-> $rose(busy_o) ##1 !erase_o [*8])
    else $error("erase pulse not at busy start");
  AST_WR_BUSY: assert property (
    arr_wr_o.we |-> busy_o)
    else $error("array write outside busy");
  AST_WR_PAGE: assert property (
    arr_wr_o.we |-> arr_wr_o.byte_address[23:8] == target_addr_o[23:8])
    else $error("array write outside page");
  AST_WRAP_HOLD: assert property (
    $changed(wrap_disable_bit_o) |-> !$past(busy_o))
    else $error("wrap changed while busy");
  AST_RD_NOWRAP: assert property (
    $past(wrap_disable_bit_o) |-> rd_next_addr_o == $past(rd_addr_i) + 24'h1)
    else $error("linear read step wrong");
  AST_RD_WRAP8: assert property (
    !$past(wrap_disable_bit_o) && $past(wrap_length_field_o) == 2'h0
      |-> ((rd_next_addr_o ^ $past(rd_addr_i)) & 24'hfffff8) == 24'h0)
    else $error("read left 8 byte section");
  cover property (erase_o && erase_blk32_o);
  cover property (arr_wr_o.we);
  cover property ($fell(wrap_disable_bit_o));
endmodule : fpw_checker
bind fpw_top fpw_checker #(.PP_CYCLES(PP_CYCLES), .SE_CYCLES(SE_CYCLES),
  .BE32_CYCLES(BE32_CYCLES)) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .latch_set_i(latch_set_i), .rd_addr_i(rd_addr_i),
  .rd_next_addr_o(rd_next_addr_o), .busy_o(busy_o),
  .write_enable_latch_o(write_enable_latch_o),
  .wrap_disable_bit_o(wrap_disable_bit_o),
  .wrap_length_field_o(wrap_length_field_o),
  .target_addr_o(target_addr_o), .arr_wr_o(arr_wr_o), .erase_o(erase_o),
  .erase_blk32_o(erase_blk32_o));
`default_nettype wire

// ==== bench/fpw_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module fpw_host_model (
  input wire logic clk_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic [3:0] data_o
);
  logic [7:0] q[$];
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    data_o = 4'h0;
  end
  // serial clock stands low outside frames, 8 clk per bit
  task automatic shift(input logic [3:0] v);
    data_o <= v;
    repeat (4) @(posedge clk_i);
    sclk_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    sclk_o <= 1'b0;
  endtask : shift
  // bytes from index qf on go out as nibbles; extra adds stray bits
  task automatic frame(input int qf, input int extra);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    foreach (q[i]) begin
      if (i >= qf) begin
        shift(q[i][7:4]);
        shift(q[i][3:0]);
      end else begin
        for (int b = 7; b >= 0; b--) begin
          shift({{3{~q[i][b]}}, q[i][b]});
        end
      end
    end
    for (int b = 0; b < extra; b++) begin
      shift(4'h5);
    end
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    data_o <= ~data_o;
    repeat (8) @(posedge clk_i);
  endtask : frame
endmodule : fpw_host_model
`default_nettype wire

// ==== bench/tb_flash_program_erase_wrap_cmds.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_flash_program_erase_wrap_cmds import fpw_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic fw_mode = 1'b0, quad_en = 1'b0, latch_set = 1'b0, lock = 1'b0;
  logic pset = 1'b0;
  logic [1:0] plen = 2'h0;
  logic [23:0] rd_a = 24'h12343f;
  fpw_prot_s prot = '0;
  logic cs_n, sclk, busy, latch, wrap_dis, erase, blk32, saw_busy, blk;
  logic [3:0] dl;
  logic [1:0] wrap_len;
  logic [23:0] rd_next, target;
  fpw_arr_wr_s arr_wr;
  logic [7:0] mem[logic [23:0]];
  int n_wr, n_er, n_errors, total_checks;
  always #25 clk_i = ~clk_i;
  fpw_host_model u_host (.clk_i(clk_i), .cs_n_o(cs_n), .sclk_o(sclk),
    .data_o(dl));
  fpw_top #(.PP_CYCLES(300), .SE_CYCLES(400), .BE32_CYCLES(500)) u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sclk_i(sclk),
    .data_line_i(dl), .four_wire_command_mode_i(fw_mode),
    .quad_enable_bit_i(quad_en), .latch_set_i(latch_set), .prot_i(prot),
    .locked_i(lock), .param_wrap_set_i(pset), .param_wrap_len_i(plen),
    .rd_addr_i(rd_a), .rd_next_addr_o(rd_next), .busy_o(busy),
    .write_enable_latch_o(latch), .wrap_disable_bit_o(wrap_dis),
    .wrap_length_field_o(wrap_len), .target_addr_o(target),
    .arr_wr_o(arr_wr), .erase_o(erase), .erase_blk32_o(blk32));
  // ****************************************
  // monitor and helpers
  // ****************************************
  // sampled on the falling edge, where outputs have settled
  always @(negedge clk_i) begin
    if (arr_wr.we) begin
      mem[arr_wr.byte_address] = arr_wr.data;
      n_wr++;
    end
    if (erase) begin
      n_er++;
      blk = blk32;
    end
    if (busy) begin
      saw_busy = 1'b1;
    end
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic go(input int qf, input int extra);
    n_wr = 0;
    n_er = 0;
    saw_busy = 1'b0;
    mem.delete();
    u_host.frame(qf, extra);
    repeat (600) begin
      @(negedge clk_i);
      if (saw_busy && !busy) break;
    end
  endtask : go
  task automatic arm();
    @(posedge clk_i);
    latch_set <= 1'b1;
    @(posedge clk_i);
    latch_set <= 1'b0;
  endtask : arm
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_wrap();
    logic [7:0] lo [4];
    // section start of 0x3f for 8, 16, 32 and 64 byte wrap
    lo = '{8'h38, 8'h30, 8'h20, 8'h00};
    for (int l = 0; l < 4; l++) begin
      u_host.q = '{FPW_OPC_WRAP_SET, 8'h0, 8'h0, 8'h0, {1'b1, 2'(l), 5'h0f}};
      go(9, 0);
      chk({wrap_dis, wrap_len}, {1'b0, 2'(l)});
      chk(rd_next, {16'h1234, lo[l]});
    end
    u_host.q = '{FPW_OPC_WRAP_SET, 8'h0, 8'h0, 8'h0, 8'h10};
    go(9, 0);
    chk(rd_next, 24'h123440);
    @(posedge clk_i);
    fw_mode <= 1'b1;
    rd_a <= 24'h1234ff;
    u_host.q = '{FPW_OPC_WRAP_SET, 8'h0, 8'h0, 8'h0, 8'h00};
    go(0, 0);
    chk(wrap_dis, 1);
    chk(rd_next, 24'h123500);
    @(posedge clk_i);
    pset <= 1'b1;
    plen <= 2'h2;
    @(posedge clk_i);
    pset <= 1'b0;
    fw_mode <= 1'b0;
    repeat (2) @(negedge clk_i);
    chk(wrap_len, 2);
  endtask : t_wrap
  task automatic t_prog();
    arm();
    u_host.q = '{FPW_OPC_PAGE_PROG, 8'h12, 8'h34, 8'hfe, 8'ha1, 8'ha2,
      8'ha3};
    go(99, 0);
    chk(saw_busy, 1);
    chk(n_wr, 3);
    chk(mem[24'h1234fe], 8'ha1);
    chk(mem[24'h123400], 8'ha3);
    chk(latch, 0);
  endtask : t_prog
  task automatic t_quad();
    @(posedge clk_i);
    quad_en <= 1'b1;
    arm();
    u_host.q = '{FPW_OPC_QUAD_PROG, 8'h00, 8'h10, 8'h05, 8'h5a};
    go(1, 0);
    chk(n_wr, 1);
    chk(mem[24'h001005], 8'h5a);
    @(posedge clk_i);
    quad_en <= 1'b0;
    arm();
    go(1, 0);
    chk({saw_busy, latch}, 2'b01);
  endtask : t_quad
  task automatic t_refuse();
    u_host.q = '{FPW_OPC_SECT_ERASE, 8'h00, 8'h20, 8'h00};
    go(99, 3);
    chk({saw_busy, latch}, 2'b01);
    @(posedge clk_i);
    prot <= 6'h07;
    go(99, 0);
    chk({saw_busy, latch}, 2'b01);
    u_host.q = '{FPW_OPC_PAGE_PROG, 8'h00, 8'h00, 8'h00, 8'h11};
    go(99, 0);
    chk({saw_busy, latch}, 2'b01);
    @(posedge clk_i);
    prot <= 6'h00;
    lock <= 1'b1;
    u_host.q = '{FPW_OPC_BLK32_ERASE, 8'h00, 8'h20, 8'h00};
    go(99, 0);
    chk({saw_busy, latch}, 2'b01);
    @(posedge clk_i);
    lock <= 1'b0;
  endtask : t_refuse
  task automatic t_erase();
    u_host.q = '{FPW_OPC_SECT_ERASE, 8'h00, 8'h2f, 8'hff};
    go(99, 0);
    chk(24'(n_er), 24'h000001);
    chk(blk, 0);
    chk(target, 24'h002fff);
    chk(latch, 0);
    u_host.q = '{FPW_OPC_PAGE_PROG, 8'h00, 8'h00, 8'h00, 8'h11};
    go(99, 0);
    chk(saw_busy, 0);
    arm();
    u_host.q = '{FPW_OPC_BLK32_ERASE, 8'h01, 8'h23, 8'h45};
    go(99, 0);
    chk(24'(n_er), 24'h000001);
    chk(blk, 1);
    chk(target, 24'h012345);
    chk(latch, 0);
  endtask : t_erase
  task automatic t_busy();
    arm();
    u_host.q = '{FPW_OPC_SECT_ERASE, 8'h00, 8'h00, 8'h00};
    u_host.frame(99, 0);
    u_host.q = '{FPW_OPC_WRAP_SET, 8'h0, 8'h0, 8'h0, 8'h00};
    go(99, 0);
    chk(wrap_dis, 1);
  endtask : t_busy
  task automatic finish_test();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (60000) @(posedge clk_i);
    n_errors++;
    finish_test();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(negedge clk_i);
    chk({wrap_dis, wrap_len, busy, latch}, 5'b10000);
    t_wrap();
    t_prog();
    t_quad();
    t_refuse();
    t_erase();
    t_busy();
    finish_test();
  end
endmodule : tb_flash_program_erase_wrap_cmds
`default_nettype wire
